/* File: rtl/watchdog_pkg.sv */
// constants, field layouts and carrier types of the windowed watchdog timer
// assumes a 125 MHz system clock and a plain strobe register port
package watchdog_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLOCK_PERIOD_NS = 8;
  localparam int unsigned OSC_HZ = 32_000;
  localparam int unsigned OSC_PERIOD_NS = 1_000_000_000 / OSC_HZ;
  // a period, so rounded down to whole cycles, never below one
  localparam int unsigned OSC_RAW_CYCLES = OSC_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam int unsigned OSC_TICK_CYCLES = (OSC_RAW_CYCLES < 1) ? 1 : OSC_RAW_CYCLES;
  localparam int unsigned BASE_TIMEOUT_SHORT_MS = 1;
  localparam int unsigned BASE_TIMEOUT_LONG_MS = 4;
  localparam logic [7:0] PRESCALE_DIV_SHORT = 8'h20;
  localparam logic [7:0] PRESCALE_DIV_LONG = 8'h80;

  // ==========================================================================
  // register map
  localparam logic [3:0] ADDR_RESET_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam int unsigned IDLE_BIT = 2;
  localparam int unsigned SLEEP_BIT = 3;
  localparam int unsigned TIMEOUT_BIT = 4;
  localparam int unsigned SOFT_EN_BIT = 5;
  localparam int unsigned POSTSCALE_LSB = 0;
  localparam int unsigned PRESCALE_BIT = 4;
  localparam int unsigned WINDOW_DIS_BIT = 6;
  localparam int unsigned FUSE_EN_BIT = 7;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic watchdog_fuse_enable;
    logic window_disable_bit;
    logic spare;
    logic prescale_select_bit;
    logic [3:0] postscale_select_field;
  } watchdog_config_word_t;

  typedef struct packed {
    logic watchdog_soft_enable;
    logic watchdog_timeout_flag;
    logic sleep_flag;
    logic idle_flag;
  } reset_control_reg_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [1:0] {RUNNING, SLEEPING, IDLING} power_state_t;

endpackage

/* File: rtl/windowed_watchdog_timer.sv */
// windowed watchdog timer with prescaler, postscaler and power-save wake-up
// assumes all inputs synchronous to clock; instruction inputs are 1-cycle pulses
// Overview of operation
// - counter runs from the low-power oscillator, which is on whenever enabled
// - prescaler divides oscillator ticks by 32 or by 128
// - base period is 1 ms or 4 ms at 32 kHz
// - postscaler divides further by one of sixteen ratios up to 32768
// - every device reset clears counter, prescaler and postscaler
// - a completed clock switch clears counter, prescaler and postscaler
// - entering sleep or idle clears counter, prescaler and postscaler
// - leaving sleep or idle clears counter, prescaler and postscaler
// - clear instruction in normal execution clears prescaler and postscaler counts
// - an enabled watchdog keeps counting during sleep and idle
// - expiry in sleep or idle wakes the core; sleep and idle flags stay
// - fuse enable set keeps the watchdog on regardless of soft enable
// - with fuse enable clear, soft enable bit five gates the watchdog
// - soft enable bit is cleared by every reset
// - in window mode a clear before the window opens forces a reset
// - time-out flag is set by hardware and cleared only by software or by power-on reset
// - prescale select one means divide by 128, zero divide by 32
// - window disable one is normal mode, zero is window mode
// - postscale code is binary, ratio two to the power of the code
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module windowed_watchdog_timer
  import watchdog_pkg::*;
#(
  // system clocks per oscillator tick, at most 4096; a bench may shorten it
  parameter int unsigned TICK_CYCLES = OSC_TICK_CYCLES
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic por,
  input wire reg_req_t reg_req,
  output logic [15:0] rdata,
  input wire logic [7:0] config_strap,
  input wire logic watchdog_clear_instr,
  input wire logic power_save_instr,
  input wire logic power_save_idle,
  input wire logic wake_event,
  input wire logic clock_switch_done,
  output logic low_power_rc_osc_on,
  output logic watchdog_reset_pulse,
  output logic wake_up
);

  // ==========================================================================
  // state
  watchdog_config_word_t cfg;
  reset_control_reg_t reset_control_reg;
  power_state_t state;
  logic [11:0] osc_cnt;
  logic [6:0] pre_cnt;
  logic [14:0] post_cnt;
  logic any_reset;
  logic enabled;
  logic running;
  logic osc_tick;
  logic pre_last;
  logic post_last;
  logic expire;
  logic exit_save;
  logic enter_save;
  logic clear_instr;
  logic early_clear;
  logic clear_counts;
  logic window_open;
  logic [6:0] pre_top;
  logic [14:0] post_top;
  logic [22:0] elapsed;
  logic [22:0] total;
  logic wr_reset_control;

  assign any_reset = reset | por;
  assign running = (state == RUNNING);
  assign enabled = cfg.watchdog_fuse_enable | reset_control_reg.watchdog_soft_enable;

  // ==========================================================================
  // configuration word, reloaded on every reset
  always_ff @(posedge clock) begin
    if (any_reset) begin
      cfg <= watchdog_config_word_t'(config_strap);
    end
  end

  // ==========================================================================
  // low-power oscillator, modelled as a tick every oscillator period
  // the tick period is rounded down, so the watchdog runs slightly fast, never late
  assign osc_tick = enabled && (osc_cnt == 12'(TICK_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (any_reset || !enabled) begin
      osc_cnt <= 12'h000;
    end else if (osc_tick) begin
      osc_cnt <= 12'h000;
    end else begin
      osc_cnt <= osc_cnt + 12'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      low_power_rc_osc_on <= 1'b0;
    end else begin
      low_power_rc_osc_on <= enabled;
    end
  end

  // ==========================================================================
  // prescaler and postscaler
  // 1 ms or 4 ms base period follows from 32 or 128 oscillator ticks
  assign pre_top = cfg.prescale_select_bit ? 7'(PRESCALE_DIV_LONG - 8'h01)
                                           : 7'(PRESCALE_DIV_SHORT - 8'h01);
  assign post_top = 15'((16'h0001 << cfg.postscale_select_field) - 16'h0001);
  assign pre_last = (pre_cnt == pre_top);
  assign post_last = (post_cnt == post_top);
  assign expire = osc_tick && pre_last && post_last;

  // window is the final quarter of the whole period
  assign elapsed = cfg.prescale_select_bit ? {1'b0, post_cnt, pre_cnt}
                                           : {3'b000, post_cnt, pre_cnt[4:0]};
  assign total = 23'({15'h0000, 8'(pre_top) + 8'h01} << cfg.postscale_select_field);
  assign window_open = (elapsed >= (total - (total >> 2)));

  assign clear_instr = watchdog_clear_instr && running;
  assign early_clear = clear_instr && enabled && !cfg.window_disable_bit
                       && !window_open;
  assign enter_save = power_save_instr && running;
  assign exit_save = !running && (expire || wake_event);
  assign clear_counts = clock_switch_done || enter_save || exit_save || clear_instr || expire;

  always_ff @(posedge clock) begin
    if (any_reset) begin
      pre_cnt <= 7'h00;
    end else if (clear_counts) begin
      pre_cnt <= 7'h00;
    end else if (osc_tick) begin
      pre_cnt <= pre_last ? 7'h00 : pre_cnt + 7'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      post_cnt <= 15'h0000;
    end else if (clear_counts) begin
      post_cnt <= 15'h0000;
    end else if (osc_tick && pre_last) begin
      post_cnt <= post_cnt + 15'h0001;
    end
  end

  // ==========================================================================
  // power state
  always_ff @(posedge clock) begin
    if (any_reset) begin
      state <= RUNNING;
    end else begin
      case (state)
        RUNNING: begin
          if (enter_save) begin
            state <= power_save_idle ? IDLING : SLEEPING;
          end
        end
        SLEEPING, IDLING: begin
          if (exit_save) begin
            state <= RUNNING;
          end
        end
        default: begin
          state <= RUNNING;
        end
      endcase
    end
  end

  // ==========================================================================
  // outputs toward reset and wake logic
  // only a request; the reset logic outside decides how long the device stays in reset
  always_ff @(posedge clock) begin
    if (any_reset) begin
      watchdog_reset_pulse <= 1'b0;
      wake_up <= 1'b0;
    end else begin
      watchdog_reset_pulse <= (expire && running) || early_clear;
      wake_up <= exit_save;
    end
  end

  // ==========================================================================
  // reset control register; hardware set wins over a software clear
  assign wr_reset_control = reg_req.wr && (reg_req.addr == ADDR_RESET_CONTROL);

  always_ff @(posedge clock) begin
    if (any_reset) begin
      reset_control_reg.watchdog_soft_enable <= 1'b0;
    end else if (wr_reset_control) begin
      reset_control_reg.watchdog_soft_enable <= reg_req.wdata[SOFT_EN_BIT];
    end
  end

  // flags survive a plain reset so software can see why it happened
  always_ff @(posedge clock) begin
    if (por) begin
      reset_control_reg.watchdog_timeout_flag <= 1'b0;
      reset_control_reg.sleep_flag <= 1'b0;
      reset_control_reg.idle_flag <= 1'b0;
    end else begin
      if (expire || early_clear) begin
        reset_control_reg.watchdog_timeout_flag <= 1'b1;
      end else if (wr_reset_control) begin
        reset_control_reg.watchdog_timeout_flag <= reg_req.wdata[TIMEOUT_BIT];
      end
      if (enter_save && !power_save_idle) begin
        reset_control_reg.sleep_flag <= 1'b1;
      end else if (wr_reset_control) begin
        reset_control_reg.sleep_flag <= reg_req.wdata[SLEEP_BIT];
      end
      if (enter_save && power_save_idle) begin
        reset_control_reg.idle_flag <= 1'b1;
      end else if (wr_reset_control) begin
        reset_control_reg.idle_flag <= reg_req.wdata[IDLE_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      rdata <= READ_ZERO;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_RESET_CONTROL: begin
          rdata <= READ_ZERO;
          rdata[SOFT_EN_BIT] <= reset_control_reg.watchdog_soft_enable;
          rdata[TIMEOUT_BIT] <= reset_control_reg.watchdog_timeout_flag;
          rdata[SLEEP_BIT] <= reset_control_reg.sleep_flag;
          rdata[IDLE_BIT] <= reset_control_reg.idle_flag;
        end
        ADDR_CONFIG: begin
          rdata <= {8'h00, cfg};
        end
        default: begin
          rdata <= READ_ZERO;
        end
      endcase
    end else begin
      rdata <= READ_ZERO;
    end
  end

  // ==========================================================================
  // checks
  AST_OSC_FOLLOWS_ENABLE: assert property (@(posedge clock) disable iff (any_reset)
    low_power_rc_osc_on == ($past(enabled) && !$past(any_reset)))
    else $error("oscillator enable does not follow watchdog enable");

  AST_PRESCALE_TOP: assert property (@(posedge clock) disable iff (any_reset)
    pre_top == (cfg.prescale_select_bit ? 7'h7f : 7'h1f))
    else $error("prescaler top wrong for select bit");

  AST_POSTSCALE_HOLDS: assert property (@(posedge clock) disable iff (any_reset)
    (osc_tick && !pre_last && !clear_counts) |=> $stable(post_cnt))
    else $error("postscaler moved without a prescaler wrap");

  AST_CLEAR_ON_SWITCH: assert property (@(posedge clock) disable iff (any_reset)
    clock_switch_done |=> (pre_cnt == 7'h00) && (post_cnt == 15'h0000))
    else $error("counts not cleared after clock switch");

  AST_CLEAR_ON_SAVE: assert property (@(posedge clock) disable iff (any_reset)
    enter_save |=> (pre_cnt == 7'h00) && (post_cnt == 15'h0000) && !running)
    else $error("power-save entry did not clear counts");

  AST_WAKE_NOT_RESET: assert property (@(posedge clock) disable iff (any_reset)
    (expire && !running) |=> wake_up && !watchdog_reset_pulse && running)
    else $error("expiry in power save did not wake");

  AST_SOFT_GATES: assert property (@(posedge clock) disable iff (any_reset)
    (!cfg.watchdog_fuse_enable && !reset_control_reg.watchdog_soft_enable)
    |=> (osc_cnt == 12'h000))
    else $error("watchdog counting while disabled");

  AST_EARLY_CLEAR_RESETS: assert property (@(posedge clock) disable iff (any_reset)
    early_clear |=> watchdog_reset_pulse && reset_control_reg.watchdog_timeout_flag)
    else $error("early clear in window mode gave no reset");

  AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (any_reset)
    (reset_control_reg.watchdog_timeout_flag && !wr_reset_control)
    |=> reset_control_reg.watchdog_timeout_flag)
    else $error("time-out flag dropped without software");

  AST_RESET_CLEARS_COUNTS: assert property (@(posedge clock) disable iff (any_reset)
    $past(any_reset) |-> (osc_cnt == 12'h000) && (pre_cnt == 7'h00) && (post_cnt == 15'h0000))
    else $error("counts not cleared by reset");

  AST_CLEAR_ON_EXIT: assert property (@(posedge clock) disable iff (any_reset)
    exit_save |=> (pre_cnt == 7'h00) && (post_cnt == 15'h0000) && running)
    else $error("power-save exit did not clear counts");

  AST_CLEAR_INSTR: assert property (@(posedge clock) disable iff (any_reset)
    clear_instr |=> (pre_cnt == 7'h00) && (post_cnt == 15'h0000))
    else $error("clear instruction did not clear counts");

  AST_COUNTS_IN_SAVE: assert property (@(posedge clock) disable iff (any_reset)
    (!running && osc_tick && !clear_counts) |=> !$stable(pre_cnt))
    else $error("prescaler stopped in power save");

  AST_SLEEP_FLAG: assert property (@(posedge clock) disable iff (any_reset)
    (enter_save && !power_save_idle) |=> reset_control_reg.sleep_flag)
    else $error("sleep flag not set on sleep entry");

  AST_WAKE_ONE_CYCLE: assert property (@(posedge clock) disable iff (any_reset)
    wake_up |=> !wake_up)
    else $error("wake pulse longer than one cycle");

  AST_FUSE_ON: assert property (@(posedge clock) disable iff (any_reset)
    cfg.watchdog_fuse_enable |=> low_power_rc_osc_on)
    else $error("fuse enable did not keep the oscillator on");

  AST_SOFT_RESET_CLEARS: assert property (@(posedge clock) disable iff (any_reset)
    $past(any_reset) |-> !reset_control_reg.watchdog_soft_enable)
    else $error("soft enable survived a reset");

  AST_LATE_CLEAR_SAFE: assert property (@(posedge clock) disable iff (any_reset)
    (clear_instr && enabled && !cfg.window_disable_bit && window_open && !expire)
    |=> !watchdog_reset_pulse)
    else $error("clear inside the window gave a reset");

  AST_POSTSCALE_TOP: assert property (@(posedge clock) disable iff (any_reset)
    post_top == (15'h7fff >> (4'hf - cfg.postscale_select_field)))
    else $error("postscaler top wrong for code");

  AST_EXPIRE_RESETS: assert property (@(posedge clock) disable iff (any_reset)
    (expire && running) |=> watchdog_reset_pulse ##1 !watchdog_reset_pulse)
    else $error("expiry did not give a one-cycle reset");

  COV_EXPIRE_RUN: cover property (@(posedge clock) disable iff (any_reset)
    expire && running);
  COV_EXPIRE_SLEEP: cover property (@(posedge clock) disable iff (any_reset)
    expire && (state == SLEEPING));
  COV_EARLY_CLEAR: cover property (@(posedge clock) disable iff (any_reset)
    early_clear);
  COV_GOOD_CLEAR: cover property (@(posedge clock) disable iff (any_reset)
    clear_instr && window_open && !cfg.window_disable_bit);
  COV_WAKE_EVENT: cover property (@(posedge clock) disable iff (any_reset)
    wake_event && !running);

endmodule

/* File: test/windowed_watchdog_timer_test.sv */
// self-checking bench for the windowed watchdog timer
// assumes the design package and a 125 MHz clock; bench drives every port itself
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
  import watchdog_pkg::*;
  // ==========================================================================
  // harness
  `define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
  // ticks shortened to 8 clocks; all tests together need about 4000 cycles
  localparam int TICK = 8;
  localparam int CEIL = 12000;
  logic clock, reset, por;
  reg_req_t reg_req;
  logic [15:0] rdata, v;
  logic [7:0] config_strap;
  logic clear_instr, power_save, power_save_idle, wake_event, clock_switch_done;
  logic osc_on, reset_pulse, wake_up;
  int err_total, n_checks, cycles, rst_seen, wake_seen, r0, w0, c0, n;

  windowed_watchdog_timer #(.TICK_CYCLES(TICK)) dut_u (
    .clock(clock), .reset(reset), .por(por), .reg_req(reg_req), .rdata(rdata),
    .config_strap(config_strap), .watchdog_clear_instr(clear_instr),
    .power_save_instr(power_save), .power_save_idle(power_save_idle),
    .wake_event(wake_event), .clock_switch_done(clock_switch_done),
    .low_power_rc_osc_on(osc_on), .watchdog_reset_pulse(reset_pulse), .wake_up(wake_up)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // pulses are counted as they stand, one cycle each
  always @(posedge clock) begin
    cycles++;
    if (reset_pulse === 1'b1) rst_seen++;
    if (wake_up === 1'b1) wake_seen++;
    if (cycles == CEIL) begin
      err_total++;
      final_report();
    end
  end

  // ==========================================================================
  // access tasks
  task automatic do_reset(input logic [7:0] strap, input logic with_por);
    config_strap <= strap;
    reset <= 1'b1;
    por <= with_por;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    por <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // 0 clear, 1 power save, 2 wake event, 3 clock switch done
  task automatic pulse(input int which);
    @(posedge clock);
    case (which)
      0: clear_instr <= 1'b1;
      1: power_save <= 1'b1;
      2: wake_event <= 1'b1;
      default: clock_switch_done <= 1'b1;
    endcase
    @(posedge clock);
    clear_instr <= 1'b0;
    power_save <= 1'b0;
    wake_event <= 1'b0;
    clock_switch_done <= 1'b0;
  endtask

  // ==========================================================================
  // tests
  initial begin
    reset = 1'b1;
    por = 1'b1;
    reg_req = '0;
    config_strap = 8'h43;
    clear_instr = 1'b0;
    power_save = 1'b0;
    power_save_idle = 1'b0;
    wake_event = 1'b0;
    clock_switch_done = 1'b0;
    do_reset(8'h43, 1'b1);
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v, 16'h0000)
    `CHK(osc_on, 1'b0)
    rd(ADDR_CONFIG, v);
    `CHK(v, 16'h0043)
    #8 `CHK(rdata, 16'h0000)
    rd(4'h7, v);
    `CHK(v, READ_ZERO)
    $display("test reset_values done");

    wr(ADDR_RESET_CONTROL, 16'h0020);
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v, 16'h0020)
    `CHK(osc_on, 1'b1)
    r0 = rst_seen;
    pulse(0);
    repeat (50) @(posedge clock);
    pulse(3);
    `CHK(rst_seen, r0)
    wr(ADDR_RESET_CONTROL, 16'h0000);
    repeat (2) @(posedge clock);
    #1 `CHK(osc_on, 1'b0)
    $display("test soft_enable done");

    do_reset(8'h00, 1'b1);
    wr(ADDR_RESET_CONTROL, 16'h0020);
    r0 = rst_seen;
    pulse(0);
    repeat (3) @(posedge clock);
    #1 `CHK(rst_seen, r0 + 1)
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v[TIMEOUT_BIT], 1'b1)
    do_reset(8'h00, 1'b0);
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v, 16'h0010)
    wr(ADDR_RESET_CONTROL, 16'h0000);
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v, 16'h0000)
    // a clear late in the period is taken, then the next expiry resets
    wr(ADDR_RESET_CONTROL, 16'h0020);
    r0 = rst_seen;
    repeat (220) @(posedge clock);
    pulse(0);
    repeat (3) @(posedge clock);
    #1 `CHK(rst_seen, r0)
    c0 = cycles;
    n = 0;
    while (rst_seen == r0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    n = cycles - c0;
    `CHK(n >= 31 * TICK - 1, 1'b1)
    `CHK(n <= 32 * TICK, 1'b1)
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v, 16'h0030)
    $display("test window_early_clear done");

    do_reset(8'h80, 1'b1);
    wr(ADDR_RESET_CONTROL, 16'h0000);
    repeat (2) @(posedge clock);
    #1 `CHK(osc_on, 1'b1)
    power_save_idle <= 1'b1;
    pulse(1);
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v[IDLE_BIT], 1'b1)
    r0 = rst_seen;
    w0 = wake_seen;
    pulse(0);
    repeat (4) @(posedge clock);
    `CHK(rst_seen, r0)
    pulse(2);
    repeat (3) @(posedge clock);
    #1 `CHK(wake_seen, w0 + 1)
    $display("test fuse_idle done");

    // long prescaler and code 1 give 256 ticks; a clock switch restarts them
    do_reset(8'hd1, 1'b1);
    r0 = rst_seen;
    repeat (1000) @(posedge clock);
    pulse(3);
    c0 = cycles;
    n = 0;
    while (rst_seen == r0 && n < 2200) begin
      @(posedge clock);
      n++;
    end
    n = cycles - c0;
    `CHK(n >= (int'(PRESCALE_DIV_LONG) * 2 - 1) * TICK, 1'b1)
    `CHK(n <= int'(PRESCALE_DIV_LONG) * 2 * TICK + 3, 1'b1)
    $display("test long_prescale done");

    // phase of the first oscillator tick is unknown, so one tick of slack below
    do_reset(8'hc0, 1'b1);
    power_save_idle <= 1'b0;
    r0 = rst_seen;
    w0 = wake_seen;
    pulse(1);
    c0 = cycles;
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v[SLEEP_BIT], 1'b1)
    n = 0;
    while (wake_seen == w0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    n = cycles - c0;
    `CHK(n >= (int'(PRESCALE_DIV_SHORT) - 1) * TICK, 1'b1)
    `CHK(n <= int'(PRESCALE_DIV_SHORT) * TICK + 8, 1'b1)
    `CHK(rst_seen, r0)
    `CHK(osc_on, 1'b1)
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v[SLEEP_BIT], 1'b1)
    wr(ADDR_RESET_CONTROL, 16'h0000);
    rd(ADDR_RESET_CONTROL, v);
    `CHK(v[SLEEP_BIT], 1'b0)
    $display("test sleep_expiry done");
    final_report();
  end
endmodule
